/* File: hw/smc_pkg.sv */
// Shared types and constants of the serial master controller
// ---------------------------------------------------------------------------
// What this block does
// - Master only, generates serial clock itself
// - Transmit and receive FIFOs of four frames
// - Data, buffers and shifter sixteen bits wide
// - ctrl0 low and ctrl1 writable only in config mode
// - Config mode resets, empties FIFOs, clears stop
// - Entering config aborts frame in progress
// - Transfers only in active mode
// - Data write to buffer starts transfer
// - Full duplex, shift out while capturing
// - Received character pushed, receive ready set
// - Receive fill flag at programmed level
// - Buffer to shifter move sets transmit ready
// - Transmit fill flag at free level 1-4
// - Back to back while data, else pause
// - Size bit selects 8 or 16 bits
// - Order bit selects MSB or LSB first
// - Phase and polarity select transfer format
// - Idle level follows polarity, phase picks edge
// - Serial clock divided by eight-bit field
// - Interframe gap in cycles, times 32 optionally
// - Write to full buffer dropped, overrun set
// ---------------------------------------------------------------------------
package smc_pkg;

  // Widths and depths
  localparam int DATA_W     = 16;
  localparam int FIFO_DEPTH = 4;
  localparam int LONG_BITS  = 16;
  localparam int SHORT_BITS = 8;
  localparam int GAP_W      = 15;
  localparam int PRESCALE_SHIFT = 5;  // Gap multiplied by 32

  // Operating modes
  localparam logic [1:0] OPM_CONFIG = 2'h1;
  localparam logic [1:0] OPM_ACTIVE = 2'h2;

  // Control word 0: low byte is the configuration-only part
  typedef struct packed {
    logic [3:0] reserved;
    logic       tx_irq_en;
    logic       rx_irq_en;
    logic [1:0] operating_mode_field;
    logic [1:0] tx_irq_threshold;       // Level minus one
    logic [1:0] rx_irq_threshold;       // Level minus one
    logic       interframe_prescale_bit;
    logic       bit_order_bit;          // 1 = LSB first
    logic       clock_polarity_bit;
    logic       clock_phase_bit;
  } smc_ctrl0_t;

  // Control word 1: writable only in configuration mode
  typedef struct packed {
    logic [9:0] interframe_delay_field;
    logic       char_size_bit;          // 1 = 16 bits
    logic [7:0] clock_divide_field;
  } smc_ctrl1_t;

  // Status word
  typedef struct packed {
    logic stop_flag;
    logic overrun_error_flag;
    logic idle_flag;
    logic tx_fill_irq_flag;
    logic tx_ready_flag;
    logic rx_fill_irq_flag;
    logic rx_ready_flag;
  } smc_status_t;

  localparam smc_ctrl0_t CTRL0_RESET = '{default: 1'b0, operating_mode_field: OPM_CONFIG};
  localparam smc_ctrl1_t CTRL1_RESET = '{default: 1'b0};
  localparam logic [7:0] CTRL0_LOW_MASK = 8'hFF;

  // Shifter states
  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_GAP} smc_state_t;

endpackage : smc_pkg

/* File: hw/smc_top.sv */
// Serial master controller: frame FIFO and top level with shifter
// ---------------------------------------------------------------------------
// Frame FIFO
// ---------------------------------------------------------------------------
module smc_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 4
) (
  input  wire logic                       clk,       // Clock
  input  wire logic                       rst_n,     // Sync reset, low
  input  wire logic                       flush,     // Empties the FIFO
  input  wire logic                       in_valid,  // Push request
  output logic                            in_ready,  // Room for a word
  input  wire logic [W-1:0]               in_data,   // Pushed word
  output logic                            out_valid, // Word available
  input  wire logic                       out_ready, // Pop request
  output logic [W-1:0]                    out_data,  // Head word
  output logic [$clog2(DEPTH+1)-1:0]      count      // Words held
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;

  // Handshake decode
  wire do_push = in_valid & in_ready;
  wire do_pop  = out_valid & out_ready;
  assign in_ready  = (count != FULL);
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  // Pointers and occupancy
  always_ff @(posedge clk) begin
    if (!rst_n || flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + CW'(do_push) - CW'(do_pop);
    end
  end

  // Storage, no reset needed
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule : smc_fifo

// ---------------------------------------------------------------------------
// Top level
// ---------------------------------------------------------------------------
module smc_top #(
  parameter int DEPTH = smc_pkg::FIFO_DEPTH
) (
  input  wire logic                     MCLK,            // 40 MHz bus clock
  input  wire logic                     RST_N,           // Sync reset, low
  input  wire logic                     CTRL0_WE,        // Control 0 write
  input  wire smc_pkg::smc_ctrl0_t      CTRL0_WDATA,     // Control 0 data
  input  wire logic                     CTRL1_WE,        // Control 1 write
  input  wire smc_pkg::smc_ctrl1_t      CTRL1_WDATA,     // Control 1 data
  input  wire logic                     DATA_WE,         // Data write
  input  wire logic [15:0]              DATA_WDATA,      // Word to send
  input  wire logic                     DATA_RE,         // Data read
  input  wire logic                     OVR_CLR,         // Clears overrun
  output smc_pkg::smc_ctrl0_t           CTRL0,           // Control 0 readback
  output smc_pkg::smc_ctrl1_t           CTRL1,           // Control 1 readback
  output smc_pkg::smc_status_t          STATUS,          // Status word
  output logic [15:0]                   RDATA,           // Word read out
  output logic                          SERIAL_CLOCK_OUT, // Serial clock
  output logic                          SERIAL_DATA_OUT, // Serial data out
  input  wire logic                     SERIAL_DATA_IN   // Serial data in
);
  import smc_pkg::*;

  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  smc_state_t    state;
  logic [7:0]    div_cnt;
  logic [4:0]    edge_cnt;
  logic [3:0]    bit_cnt;
  logic [15:0]   tx_word;
  logic [15:0]   rx_sh;
  logic [GAP_W-1:0] gap_cnt;
  logic          din_meta;
  logic          din_sync;

  logic          tx_in_ready;
  logic          tx_out_valid;
  logic [15:0]   tx_out_data;
  logic [CW-1:0] tx_count;
  logic          rx_in_ready;
  logic          rx_out_valid;
  logic [15:0]   rx_out_data;
  logic [CW-1:0] rx_count;

  // ---------------------------------------------------------------------------
  // Mode and write decode
  // ---------------------------------------------------------------------------
  wire in_cfg    = (CTRL0.operating_mode_field == OPM_CONFIG);
  wire in_active = (CTRL0.operating_mode_field == OPM_ACTIVE);
  // data write queues a word, only when active
  wire tx_push   = DATA_WE & in_active;
  // write to full buffer is dropped
  wire overrun   = tx_push & ~tx_in_ready;
  wire rx_pop    = DATA_RE & rx_out_valid;

  // ---------------------------------------------------------------------------
  // Shifter decode
  // ---------------------------------------------------------------------------
  // character length from size bit
  wire [4:0] nbits    = CTRL1.char_size_bit ? 5'(LONG_BITS) : 5'(SHORT_BITS);
  wire [4:0] last_e   = 5'((nbits << 1) - 5'h1);
  // half period is divide field plus one cycles
  wire       tick     = (state == ST_SHIFT) && (div_cnt == CTRL1.clock_divide_field);
  // phase 0 samples even edges, phase 1 odd ones
  wire       smp_edge = CTRL0.clock_phase_bit ? edge_cnt[0] : ~edge_cnt[0];
  wire       last     = (edge_cnt == last_e);
  wire       chg_edge = ~smp_edge && (edge_cnt != 5'h0) && ~last;
  wire [3:0] next_bit = bit_cnt + 4'h1;
  wire [3:0] idx_next = CTRL0.bit_order_bit ? next_bit : 4'(nbits - 5'h1 - 5'(next_bit));
  wire [3:0] idx_first = CTRL0.bit_order_bit ? 4'h0 : 4'(nbits - 5'h1);
  wire [15:0] rx_capt = CTRL0.bit_order_bit ? {din_sync, rx_sh[15:1]} : {rx_sh[14:0], din_sync};
  wire [15:0] rx_raw  = smp_edge ? rx_capt : rx_sh;
  wire [15:0] rx_word = CTRL1.char_size_bit ? rx_raw :
                        (CTRL0.bit_order_bit ? {8'h00, rx_raw[15:8]} : {8'h00, rx_raw[7:0]});
  wire frame_done = tick && last;
  // active only; next frame if data waits and room
  wire start = in_active && (state == ST_IDLE) && tx_out_valid && rx_in_ready;
  wire [GAP_W-1:0] gap_len = CTRL0.interframe_prescale_bit ?
                     GAP_W'({CTRL1.interframe_delay_field, 5'h00}) :
                     GAP_W'(CTRL1.interframe_delay_field);

  // ---------------------------------------------------------------------------
  // Buffers
  // ---------------------------------------------------------------------------
  // four-frame transmit FIFO, sixteen bits; flushed in config
  smc_fifo #(.W(DATA_W), .DEPTH(DEPTH)) u_tx_fifo (
    .clk       (MCLK),
    .rst_n     (RST_N),
    .flush     (in_cfg),
    .in_valid  (tx_push),
    .in_ready  (tx_in_ready),
    .in_data   (DATA_WDATA),
    .out_valid (tx_out_valid),
    .out_ready (start),
    .out_data  (tx_out_data),
    .count     (tx_count)
  );

  smc_fifo #(.W(DATA_W), .DEPTH(DEPTH)) u_rx_fifo (
    .clk       (MCLK),
    .rst_n     (RST_N),
    .flush     (in_cfg),
    .in_valid  (frame_done),
    .in_ready  (rx_in_ready),
    .in_data   (rx_word),
    .out_valid (rx_out_valid),
    .out_ready (rx_pop),
    .out_data  (rx_out_data),
    .count     (rx_count)
  );

  // ---------------------------------------------------------------------------
  // Control words
  // ---------------------------------------------------------------------------
  // low byte and control 1 only while in config mode
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      CTRL0 <= CTRL0_RESET;
      CTRL1 <= CTRL1_RESET;
    end else begin
      if (CTRL0_WE) begin
        CTRL0[15:8] <= CTRL0_WDATA[15:8];
        if (in_cfg) begin
          CTRL0[7:0] <= CTRL0_WDATA[7:0] & CTRL0_LOW_MASK;
        end
      end
      if (CTRL1_WE && in_cfg) begin
        CTRL1 <= CTRL1_WDATA;
      end
    end
  end

  // Two-flop synchroniser for the serial input pin
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      din_meta <= 1'b0;
      din_sync <= 1'b0;
    end else begin
      din_meta <= SERIAL_DATA_IN;
      din_sync <= din_meta;
    end
  end

  // ---------------------------------------------------------------------------
  // Shift engine
  // ---------------------------------------------------------------------------
  // clock generated here; config forces idle and aborts
  always_ff @(posedge MCLK) begin
    if (!RST_N || in_cfg) begin
      state            <= ST_IDLE;
      div_cnt          <= '0;
      edge_cnt         <= '0;
      bit_cnt          <= '0;
      tx_word          <= '0;
      rx_sh            <= '0;
      gap_cnt          <= '0;
      SERIAL_CLOCK_OUT <= !RST_N ? 1'b0 : CTRL0.clock_polarity_bit;
      SERIAL_DATA_OUT  <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          SERIAL_CLOCK_OUT <= CTRL0.clock_polarity_bit;
          if (start) begin
            state           <= ST_SHIFT;
            tx_word         <= tx_out_data;
            rx_sh           <= '0;
            div_cnt         <= '0;
            edge_cnt        <= '0;
            bit_cnt         <= '0;
            SERIAL_DATA_OUT <= tx_out_data[idx_first];
          end
        end
        ST_SHIFT: begin
          div_cnt <= tick ? 8'h00 : div_cnt + 8'h01;
          if (tick) begin
            // toggle clock, format picks sample or change
            SERIAL_CLOCK_OUT <= ~SERIAL_CLOCK_OUT;
            edge_cnt         <= edge_cnt + 5'h01;
            if (smp_edge) begin
              rx_sh <= rx_capt;
            end
            if (chg_edge) begin
              bit_cnt         <= next_bit;
              SERIAL_DATA_OUT <= tx_word[idx_next];
            end
            if (last) begin
              gap_cnt <= gap_len;
              state   <= (gap_len != '0) ? ST_GAP : ST_IDLE;
            end
          end
        end
        ST_GAP: begin
          gap_cnt <= gap_cnt - 1'b1;
          if (gap_cnt == GAP_W'(1)) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Status and read data
  // ---------------------------------------------------------------------------
  wire [CW-1:0] tx_free   = FULL_CNT - tx_count;
  wire [CW-1:0] rx_level  = CW'({1'b0, CTRL0.rx_irq_threshold}) + CW'(1);
  wire [CW-1:0] tx_level  = CW'({1'b0, CTRL0.tx_irq_threshold}) + CW'(1);
  wire rx_fill = CTRL0.rx_irq_en && (rx_count >= rx_level);
  // transmit fill flag on enough free slots
  wire tx_fill = CTRL0.tx_irq_en && (tx_free >= tx_level);
  // idle needs empty buffer and stopped shifter
  wire idle    = (tx_count == '0) && (state == ST_IDLE);
  // Flag writes; set terms win over clears
  wire next_rx_rdy = frame_done | (STATUS.rx_ready_flag & ~(rx_pop && rx_count == CW'(1)));
  wire tx_fills    = tx_push && tx_in_ready && (tx_count == FULL_CNT - CW'(1)) && !start;
  wire next_tx_rdy = start | (STATUS.tx_ready_flag & ~tx_fills);
  wire next_ovr    = overrun | (STATUS.overrun_error_flag & ~OVR_CLR);
  wire next_stop   = frame_done ? (tx_count == '0) : (STATUS.stop_flag & ~start);

  // Status register; config clears stop and buffer flags
  always_ff @(posedge MCLK) begin
    if (!RST_N || in_cfg) begin
      STATUS       <= '0;
      STATUS.idle_flag          <= RST_N;
      STATUS.overrun_error_flag <= RST_N & STATUS.overrun_error_flag & ~OVR_CLR;
      RDATA        <= '0;
    end else begin
      STATUS.rx_ready_flag      <= next_rx_rdy;
      STATUS.rx_fill_irq_flag   <= rx_fill;
      // transmit ready when entry enters shifter
      STATUS.tx_ready_flag      <= next_tx_rdy;
      STATUS.tx_fill_irq_flag   <= tx_fill;
      STATUS.idle_flag          <= idle;
      STATUS.overrun_error_flag <= next_ovr;
      STATUS.stop_flag          <= next_stop;
      if (rx_pop) begin
        RDATA <= rx_out_data;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  a_cfg_flushes: assert property (@(posedge MCLK) disable iff (!RST_N)
    in_cfg |=> (tx_count == '0) && (rx_count == '0) && !STATUS.stop_flag)
    else $error("config mode did not empty buffers");

  a_cfg_aborts: assert property (@(posedge MCLK) disable iff (!RST_N)
    (state == ST_SHIFT) && in_cfg |=> (state == ST_IDLE))
    else $error("frame not aborted on config");

  a_start_needs_active: assert property (@(posedge MCLK) disable iff (!RST_N)
    (state == ST_IDLE) && !in_active |=> (state == ST_IDLE))
    else $error("transfer began outside active mode");

  a_write_starts: assert property (@(posedge MCLK) disable iff (!RST_N)
    in_active && (state == ST_IDLE) && tx_out_valid && rx_in_ready && !CTRL0_WE
      |=> (state == ST_SHIFT))
    else $error("queued word did not start a frame");

  a_ctrl1_locked: assert property (@(posedge MCLK) disable iff (!RST_N)
    CTRL1_WE && !in_cfg |=> $stable(CTRL1))
    else $error("control 1 changed outside config");

  a_rx_ready_set: assert property (@(posedge MCLK) disable iff (!RST_N)
    frame_done && !CTRL0_WE |=> STATUS.rx_ready_flag && (rx_count != '0))
    else $error("receive ready missing after frame");

  a_tx_ready_set: assert property (@(posedge MCLK) disable iff (!RST_N)
    start && !CTRL0_WE |=> STATUS.tx_ready_flag)
    else $error("transmit ready missing after load");

  a_overrun_flag: assert property (@(posedge MCLK) disable iff (!RST_N)
    overrun && !CTRL0_WE |=> STATUS.overrun_error_flag &&
      (tx_count == $past(tx_count) - CW'($past(start))))
    else $error("overrun not flagged or word stored");

  a_idle_clock: assert property (@(posedge MCLK) disable iff (!RST_N)
    (state == ST_IDLE) && $past(state == ST_IDLE) && $stable(CTRL0)
      |-> (SERIAL_CLOCK_OUT == CTRL0.clock_polarity_bit))
    else $error("serial clock off idle level");

  a_idle_status: assert property (@(posedge MCLK) disable iff (!RST_N)
    STATUS.idle_flag && !$past(in_cfg) |-> $past(tx_count == '0 && state == ST_IDLE))
    else $error("idle shown while busy");

  a_frame_edges: assert property (@(posedge MCLK) disable iff (!RST_N)
    frame_done |-> (edge_cnt == (CTRL1.char_size_bit ? 5'h1F : 5'h0F)))
    else $error("frame edge count wrong");
endmodule : smc_top

/* File: test/smc_slave_model.sv */
// Behavioural serial slave that answers the controller
module smc_slave_model (
  input  wire logic        clk,     // Bench clock
  input  wire logic        cs_n,    // Chip select, low
  input  wire logic        sclk,    // Serial clock in
  input  wire logic        mosi,    // Data from master
  input  wire logic        cpha,    // Phase setting
  input  wire logic        lsb,     // LSB first
  input  wire logic        sz16,    // 16-bit frames
  input  wire logic [15:0] tx_word, // Word to answer
  output logic             miso,    // Data to master
  output logic [15:0]      rx_last, // Last word taken
  output logic [15:0]      rx_prev  // Word before it
);
  timeunit 1ns;
  timeprecision 100ps;
  int          n;
  int          dv;
  int          sk;
  logic        odd;
  logic [15:0] sh;

  assign n = sz16 ? 16 : 8;

  // Bit position of the k-th bit on the wire
  function automatic int pos(input int k);
    return lsb ? k : n - 1 - k;
  endfunction : pos

  initial miso = 1'b0;

  always @(posedge clk) begin
    if (cs_n) begin
      miso <= ~miso;
    end
  end

  // selection starts a frame, phase 0 presets bit 0
  always @(negedge cs_n) begin
    odd = 1'b1;
    dv = cpha ? 0 : 1;
    sk = 0;
    sh = '0;
    if (!cpha) begin
      miso <= tx_word[pos(0)];
    end
  end

  // sample on one edge kind, change on the other
  always @(sclk) begin
    if (!cs_n) begin
      if (odd != cpha) begin
        sh[pos(sk)] = mosi;
        sk = sk + 1;
        if (sk == n) begin
          rx_prev <= rx_last;
          rx_last <= sh;
          sk = 0;
        end
      end else begin
        miso <= tx_word[pos(dv)];
        dv = (dv + 1) % n;
      end
      odd = ~odd;
    end
  end
endmodule : smc_slave_model

/* File: test/testbench.sv */
// Self-checking bench of the serial master controller
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import smc_pkg::*;
  // ---------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------
  localparam logic [6:0] M_IDLE = 7'h10;
  localparam logic [6:0] M_TX   = 7'h0C;
  localparam logic [6:0] M_RX   = 7'h03;
  logic        MCLK;
  logic        RST_N = 1'b0, CTRL0_WE = 1'b0, CTRL1_WE = 1'b0, OVR_CLR = 1'b0;
  logic        DATA_WE = 1'b0, DATA_RE = 1'b0, cs_n = 1'b1, armed = 1'b0;
  logic        cpol = 1'b0, cpha = 1'b0, lsb = 1'b0, sz = 1'b0, last_sclk = 1'b0;
  logic        SCLK, MOSI, MISO;
  smc_ctrl0_t  CTRL0_WDATA = CTRL0_RESET, CTRL0, c0;
  smc_ctrl1_t  CTRL1_WDATA = CTRL1_RESET, CTRL1, c1;
  smc_status_t STATUS;
  logic [15:0] DATA_WDATA = 16'h0000, s_tx = 16'h0000, RDATA, s_rx, s_prev, msk;
  int          errors = 0, checks_done = 0, quiet = 0, max_q = 0, i;

  smc_top #(.DEPTH(FIFO_DEPTH)) u_smc_top (
    .MCLK(MCLK), .RST_N(RST_N), .CTRL0_WE(CTRL0_WE), .CTRL0_WDATA(CTRL0_WDATA),
    .CTRL1_WE(CTRL1_WE), .CTRL1_WDATA(CTRL1_WDATA), .DATA_WE(DATA_WE),
    .DATA_WDATA(DATA_WDATA), .DATA_RE(DATA_RE), .OVR_CLR(OVR_CLR), .CTRL0(CTRL0),
    .CTRL1(CTRL1), .STATUS(STATUS), .RDATA(RDATA), .SERIAL_CLOCK_OUT(SCLK),
    .SERIAL_DATA_OUT(MOSI), .SERIAL_DATA_IN(MISO));

  smc_slave_model u_smc_slave_model (
    .clk(MCLK), .cs_n(cs_n), .sclk(SCLK), .mosi(MOSI), .cpha(cpha), .lsb(lsb),
    .sz16(sz), .tx_word(s_tx), .miso(MISO), .rx_last(s_rx), .rx_prev(s_prev));

  // Bus clock, 25 ns period
  initial begin
    MCLK = 1'b0;
    forever #12.5 MCLK = ~MCLK;
  end

  // Longest serial clock pause once a transfer series is under way
  always @(posedge MCLK) begin
    quiet <= quiet + 1;
    if (SCLK !== last_sclk) begin
      if (armed && quiet > max_q) max_q <= quiet;
      quiet <= 0;
      armed <= 1'b1;
    end
    last_sclk <= SCLK;
  end
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_val

  // One-cycle strobe, driven between rising edges
  task automatic pulse(ref logic s);
    @(negedge MCLK);
    s = 1'b1;
    @(negedge MCLK);
    s = 1'b0;
  endtask : pulse

  // Bounded wait for any status bit of a mask
  task automatic wait_st(input logic [6:0] m);
    int n = 0;
    while ((|(STATUS & m)) !== 1'b1 && n < 20000) begin
      @(negedge MCLK);
      n++;
    end
    if (n == 20000) errors++;
  endtask : wait_st

  task automatic rd_chk(input logic [15:0] exp);
    pulse(DATA_RE);
    @(negedge MCLK);
    check_val(RDATA, exp);
  endtask : rd_chk

  // Config first, then active; the switching write still sees config
  task automatic set_mode(input logic [9:0] gap, input logic pre, input logic [7:0] dv);
    smc_ctrl0_t c;
    smc_ctrl1_t d;
    c = CTRL0_RESET;
    CTRL0_WDATA = c;
    pulse(CTRL0_WE);
    d = '{interframe_delay_field: gap, char_size_bit: sz, clock_divide_field: dv};
    CTRL1_WDATA = d;
    pulse(CTRL1_WE);
    c = '{4'h0, 1'b1, 1'b1, OPM_CONFIG, 2'h3, 2'h1, pre, lsb, cpol, cpha};
    CTRL0_WDATA = c;
    pulse(CTRL0_WE);
    c.operating_mode_field = OPM_ACTIVE;
    CTRL0_WDATA = c;
    pulse(CTRL0_WE);
    @(negedge MCLK);
    check_val(CTRL0, c);
    check_val(CTRL1, d);
  endtask : set_mode

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  // Watchdog, well beyond the expected run
  initial begin
    #(25 * 40000);
    errors++;
    tally_and_finish();
  end

  initial begin
    repeat (8) @(negedge MCLK);
    check_val(CTRL0, CTRL0_RESET);
    check_val(CTRL1, CTRL1_RESET);
    RST_N = 1'b1;
    repeat (2) @(negedge MCLK);
    check_val(STATUS.idle_flag, 1'b1);
    check_val(SCLK, 1'b0);
    // Every format, order and size; last one with a prescaled gap
    for (i = 0; i < 4; i++) begin
      {cpol, cpha} = 2'(i);
      lsb = cpol ^ cpha;
      sz = cpol;
      msk = sz ? 16'hFFFF : 16'h00FF;
      s_tx = 16'hC3A5 + 16'(i);
      set_mode((i == 3) ? 10'h003 : 10'h000, i == 3, 8'h03);
      cs_n = 1'b0;
      wait_st(M_TX);
      DATA_WDATA = 16'hA55A + 16'(i);
      pulse(DATA_WE);
      wait_st(M_TX);
      DATA_WDATA = 16'h3C96 - 16'(i);
      pulse(DATA_WE);
      armed = 1'b0;
      max_q = 0;
      wait_st(M_RX);
      wait_st(M_IDLE);
      cs_n = 1'b1;
      check_val(s_prev, (16'hA55A + 16'(i)) & msk);
      check_val(s_rx, (16'h3C96 - 16'(i)) & msk);
      check_val(STATUS.rx_fill_irq_flag, 1'b1);
      check_val(STATUS.tx_fill_irq_flag, 1'b1);
      check_val(STATUS.stop_flag, 1'b1);
      check_val(SCLK, cpol);
      if (i == 3) check_val(max_q >= 96 && max_q <= 112, 1'b1);
      else check_val(max_q < 32, 1'b1);
      rd_chk(s_tx & msk);
      check_val(STATUS.rx_fill_irq_flag, 1'b0);
      rd_chk(s_tx & msk);
      check_val(STATUS.rx_ready_flag, 1'b0);
    end
    // Data write in config mode is dropped
    {cpol, cpha, lsb, sz} = 4'h0;
    CTRL0_WDATA = CTRL0_RESET;
    pulse(CTRL0_WE);
    DATA_WDATA = 16'h00AA;
    pulse(DATA_WE);
    set_mode(10'h000, 1'b0, 8'hFF);
    // Neither mode: no flush here, so a taken word would start later
    c0 = CTRL0;
    c0.operating_mode_field = 2'h0;
    CTRL0_WDATA = c0;
    pulse(CTRL0_WE);
    pulse(DATA_WE);
    c0.operating_mode_field = OPM_ACTIVE;
    CTRL0_WDATA = c0;
    pulse(CTRL0_WE);
    repeat (8) @(negedge MCLK);
    check_val(STATUS.idle_flag, 1'b1);
    // Fill the buffer behind a slow frame, then overflow it
    pulse(DATA_WE);
    repeat (4) @(negedge MCLK);
    check_val(STATUS.tx_ready_flag, 1'b1);
    check_val(STATUS.idle_flag, 1'b0);
    repeat (4) pulse(DATA_WE);
    @(negedge MCLK);
    check_val(STATUS.tx_ready_flag, 1'b0);
    check_val(STATUS.overrun_error_flag, 1'b0);
    pulse(DATA_WE);
    @(negedge MCLK);
    check_val(STATUS.overrun_error_flag, 1'b1);
    // Config mid-frame aborts and flushes
    CTRL0_WDATA = CTRL0_RESET;
    pulse(CTRL0_WE);
    repeat (2) @(negedge MCLK);
    check_val(STATUS.idle_flag, 1'b1);
    check_val(STATUS.stop_flag, 1'b0);
    check_val(SCLK, 1'b0);
    check_val(STATUS.overrun_error_flag, 1'b1);
    pulse(OVR_CLR);
    @(negedge MCLK);
    check_val(STATUS.overrun_error_flag, 1'b0);
    set_mode(10'h000, 1'b0, 8'h03);
    repeat (8) @(negedge MCLK);
    check_val(STATUS.idle_flag, 1'b1);
    check_val(STATUS.rx_ready_flag, 1'b0);
    // Active mode locks the low control byte and control word 1
    c0 = CTRL0;
    CTRL0_WDATA = c0 ^ 16'h08FF;
    pulse(CTRL0_WE);
    @(negedge MCLK);
    check_val(CTRL0, c0 ^ 16'h0800);
    c1 = CTRL1;
    CTRL1_WDATA = ~c1;
    pulse(CTRL1_WE);
    @(negedge MCLK);
    check_val(CTRL1, c1);
    tally_and_finish();
  end
endmodule : testbench
